// ===== design/awr_pkg.sv
// Register map, field layout and carrier types of the auxiliary wake block.
package awr_pkg;

  // Register offsets in the configuration index space.
  localparam logic [7:0] OFF_PIN_MUX = 8'hC0;
  localparam logic [7:0] OFF_OVERRIDE = 8'hC1;
  localparam logic [7:0] OFF_RATE_SHADOW = 8'hC2;
  localparam logic [7:0] OFF_SERIAL1_SHADOW = 8'hC3;
  localparam logic [7:0] OFF_SERIAL2_SHADOW = 8'hC4;
  localparam logic [7:0] OFF_WAKE_CTRL = 8'hC5;
  localparam logic [7:0] OFF_WAKE_FLAG = 8'hC6;
  localparam logic [7:0] OFF_WAKE_STATUS = 8'hC7;
  localparam logic [7:0] OFF_WAKE_ENABLE = 8'hC8;

  // Pin multiplex control.
  localparam logic [7:0] PIN_MUX_MASK = 8'h0A;
  localparam logic [7:0] PIN_MUX_RESET = 8'h02;
  localparam int PIN_MUX_DMA3_BIT = 1;
  localparam int PIN_MUX_KBC_BIT = 3;

  // Disk-change override; bits other than the force bit read as reset.
  localparam logic [7:0] OVERRIDE_RESET = 8'h03;
  localparam logic [7:0] OVERRIDE_FIXED_MASK = 8'hFE;
  localparam int FORCE_BIT = 0;

  // Shadow copies; reserved bits read as zero.
  localparam logic [7:0] RATE_SHADOW_MASK = 8'hDF;
  localparam logic [7:0] FIFO_SHADOW_MASK = 8'hCF;
  localparam logic [7:0] SHADOW_RESET = 8'h00;

  // Wake registers.
  localparam logic [7:0] WAKE_CTRL_MASK = 8'h01;
  localparam logic [7:0] WAKE_FLAG_MASK = 8'h01;
  localparam logic [7:0] WAKE_SRC_MASK = 8'h1E;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  localparam int WAKE_EN_BIT = 0;
  localparam int WAKE_FLAG_BIT = 0;
  localparam int SRC_RING2_BIT = 1;
  localparam int SRC_RING1_BIT = 2;
  localparam int SRC_KEYBOARD_BIT = 3;
  localparam int SRC_MOUSE_BIT = 4;

  typedef struct packed {
    logic strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } awr_write_t;

  typedef struct packed {
    logic strobe;
    logic [7:0] data;
  } awr_shadow_t;

  function automatic logic awrHit(awr_write_t w, logic [7:0] off);
    return w.strobe && (w.addr == off);
  endfunction

endpackage

// ===== design/awr_sync.sv
// Two-stage synchroniser for pins that enter the clock domain.
`timescale 1ns/1ns
module awr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input logic clock,
  input logic nrst,
  input logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] firstStage;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      firstStage <= IDLE;
      syncOut <= IDLE;
    end else begin
      firstStage <= pinIn;
      syncOut <= firstStage;
    end
  end
endmodule

// ===== design/awr_wake.sv
// Wake registers and wake event logic, kept on the standby reset only.
`timescale 1ns/1ns
module awr_wake (
  input logic clock,
  input logic nrst,
  input awr_pkg::awr_write_t busWrite,
  input logic [7:0] wakeEvents,
  output logic [7:0] wakeControl,
  output logic [7:0] wakeFlag,
  output logic [7:0] wakeStatus,
  output logic [7:0] wakeEnable,
  output logic wakeFire,
  output logic wakeDrive
);
  import awr_pkg::*;

  logic flagClear;
  logic statusWrite;

  // An enabled source fires whether or not the line itself is enabled.
  assign wakeFire = |(wakeEvents & wakeEnable
    & WAKE_SRC_MASK);
  assign flagClear = awrHit(busWrite, OFF_WAKE_FLAG)
    && busWrite.data[WAKE_FLAG_BIT];
  assign statusWrite = awrHit(busWrite, OFF_WAKE_STATUS);
  assign wakeDrive = wakeFlag[WAKE_FLAG_BIT]
    & wakeControl[WAKE_EN_BIT];

  // None of these see the main-supply reset, only the standby one.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wakeControl <= WAKE_RESET;
    end else if (awrHit(busWrite, OFF_WAKE_CTRL)) begin
      wakeControl <= busWrite.data & WAKE_CTRL_MASK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wakeEnable <= WAKE_RESET;
    end else if (awrHit(busWrite, OFF_WAKE_ENABLE)) begin
      wakeEnable <= busWrite.data & WAKE_SRC_MASK;
    end
  end

  // A fire in the clearing cycle keeps the flag set.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wakeFlag <= WAKE_RESET;
    end else if (wakeFire) begin
      wakeFlag <= WAKE_FLAG_MASK;
    end else if (flagClear) begin
      wakeFlag <= WAKE_RESET;
    end
  end

  // Sources latch regardless of enables; write-one clears, set wins.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wakeStatus <= WAKE_RESET;
    end else if (statusWrite) begin
      wakeStatus <= ((wakeStatus & ~busWrite.data) | wakeEvents)
        & WAKE_SRC_MASK;
    end else begin
      wakeStatus <= (wakeStatus | wakeEvents) & WAKE_SRC_MASK;
    end
  end
endmodule

// ===== design/awr_regs.sv
// Top of the auxiliary configuration, shadow and wake register bank.
`timescale 1ns/1ns

// What this block does
// - Software sets force bit; writing zero ignored.
// - Step with drive 0 clears; reset 0x03.
// - Disk-change flag ORs raw input, forced term.
// - Read-only copy of floppy data-rate register.
// - Read-back copies of both serial FIFO controls.
// - Wake line driven only when enable set.
// - Wake registers cleared by standby reset only.
// - Wake flag sets whenever line would assert.
// - Writing one clears flag and releases line.
// - Source status latches events regardless of enables.
// - Write one clears status bit; zero ignored.
// - Enabled source with line enable asserts wake.
// - Disabled source records status, never drives wake.
module awr_regs (
  input logic clock,
  input logic nrst,
  input logic mainPorReset,
  input logic [7:0] regAddr,
  input logic [7:0] regWrData,
  input logic regWr,
  input logic regRd,
  output logic [7:0] regRdData,
  input awr_pkg::awr_shadow_t rateWrite,
  input awr_pkg::awr_shadow_t serial1Write,
  input awr_pkg::awr_shadow_t serial2Write,
  input logic stepPulseN,
  input logic drive0SelectN,
  input logic diskChangeInN,
  input logic ringPort1Wake,
  input logic ringPort2Wake,
  input logic keyboardWake,
  input logic mouseWake,
  output logic diskChangedFlag,
  output logic dma3Select,
  output logic kbcPinSelect,
  output logic wakeLineOut,
  output logic wakeLineOeN
);
  import awr_pkg::*;

  awr_write_t busWrite;
  logic [2:0] floppyPins;
  logic [2:0] floppySync;
  logic [3:0] wakePins;
  logic [3:0] wakeSync;
  logic [7:0] wakeEvents;
  logic stepSync;
  logic drive0Sync;
  logic diskInSync;
  logic stepPrev;
  logic stepClear;
  logic forceSet;
  logic forceChange;
  logic [7:0] pinMux;
  logic [7:0] overrideRead;
  logic [7:0] rateShadow;
  logic [7:0] serial1Shadow;
  logic [7:0] serial2Shadow;
  logic [7:0] wakeControl;
  logic [7:0] wakeFlag;
  logic [7:0] wakeStatus;
  logic [7:0] wakeEnable;
  logic wakeFire;
  logic wakeDrive;
  logic [7:0] next_regRdData;

  assign busWrite = '{strobe: regWr, addr: regAddr, data: regWrData};

  // Floppy pins idle high, so they synchronise from an inactive value.
  assign floppyPins = {stepPulseN, drive0SelectN, diskChangeInN};

  awr_sync #(
    .WIDTH(3),
    .IDLE(3'h7)
  ) u_floppy_sync (
    .clock(clock),
    .nrst(nrst),
    .pinIn(floppyPins),
    .syncOut(floppySync)
  );

  assign stepSync = floppySync[2];
  assign drive0Sync = floppySync[1];
  assign diskInSync = floppySync[0];

  assign wakePins = {mouseWake, keyboardWake, ringPort1Wake, ringPort2Wake};

  awr_sync #(
    .WIDTH(4),
    .IDLE(4'h0)
  ) u_wake_sync (
    .clock(clock),
    .nrst(nrst),
    .pinIn(wakePins),
    .syncOut(wakeSync)
  );

  // Align the sources with their bit positions in the wake registers.
  always_comb begin
    wakeEvents = 8'h00;
    wakeEvents[SRC_RING2_BIT] = wakeSync[0];
    wakeEvents[SRC_RING1_BIT] = wakeSync[1];
    wakeEvents[SRC_KEYBOARD_BIT] = wakeSync[2];
    wakeEvents[SRC_MOUSE_BIT] = wakeSync[3];
  end

  // Only the falling edge of the step pulse counts, so a step held low
  // does not keep eating a force that software sets meanwhile.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stepPrev <= 1'b1;
    end else begin
      stepPrev <= stepSync;
    end
  end

  assign stepClear = stepPrev && !stepSync && !drive0Sync;
  assign forceSet = awrHit(busWrite, OFF_OVERRIDE)
    && busWrite.data[FORCE_BIT];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinMux <= PIN_MUX_RESET;
    end else if (mainPorReset) begin
      pinMux <= PIN_MUX_RESET;
    end else if (awrHit(busWrite, OFF_PIN_MUX)) begin
      pinMux <= busWrite.data & PIN_MUX_MASK;
    end
  end

  assign dma3Select = pinMux[PIN_MUX_DMA3_BIT];
  assign kbcPinSelect = pinMux[PIN_MUX_KBC_BIT];

  // A software set in the same cycle as a step wins over the clear.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      forceChange <= OVERRIDE_RESET[FORCE_BIT];
    end else if (mainPorReset) begin
      forceChange <= OVERRIDE_RESET[FORCE_BIT];
    end else if (forceSet) begin
      forceChange <= 1'b1;
    end else if (stepClear) begin
      forceChange <= 1'b0;
    end
  end

  assign overrideRead = (OVERRIDE_RESET & OVERRIDE_FIXED_MASK)
    | {7'h00, forceChange};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      diskChangedFlag <= 1'b1;
    end else begin
      diskChangedFlag <= diskInSync | (drive0Sync & forceChange);
    end
  end

  // Shadows exist because the originals cannot be read back.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rateShadow <= SHADOW_RESET;
    end else if (rateWrite.strobe) begin
      rateShadow <= rateWrite.data & RATE_SHADOW_MASK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      serial1Shadow <= SHADOW_RESET;
    end else if (serial1Write.strobe) begin
      serial1Shadow <= serial1Write.data & FIFO_SHADOW_MASK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      serial2Shadow <= SHADOW_RESET;
    end else if (serial2Write.strobe) begin
      serial2Shadow <= serial2Write.data & FIFO_SHADOW_MASK;
    end
  end

  awr_wake u_wake (
    .clock(clock),
    .nrst(nrst),
    .busWrite(busWrite),
    .wakeEvents(wakeEvents),
    .wakeControl(wakeControl),
    .wakeFlag(wakeFlag),
    .wakeStatus(wakeStatus),
    .wakeEnable(wakeEnable),
    .wakeFire(wakeFire),
    .wakeDrive(wakeDrive)
  );

  // The wake line is open drain: it is pulled low or released.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wakeLineOut <= 1'b1;
      wakeLineOeN <= 1'b1;
    end else begin
      wakeLineOut <= !wakeDrive;
      wakeLineOeN <= !wakeDrive;
    end
  end

  always_comb begin
    next_regRdData = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        OFF_PIN_MUX: next_regRdData = pinMux;
        OFF_OVERRIDE: next_regRdData = overrideRead;
        OFF_RATE_SHADOW: next_regRdData = rateShadow;
        OFF_SERIAL1_SHADOW: next_regRdData = serial1Shadow;
        OFF_SERIAL2_SHADOW: next_regRdData = serial2Shadow;
        OFF_WAKE_CTRL: next_regRdData = wakeControl;
        OFF_WAKE_FLAG: next_regRdData = wakeFlag;
        OFF_WAKE_STATUS: next_regRdData = wakeStatus;
        OFF_WAKE_ENABLE: next_regRdData = wakeEnable;
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  // Read data stand for one cycle only and are zero otherwise.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= next_regRdData;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  a_force_sw_set: assert property (
    forceSet && !mainPorReset |=> forceChange
  ) else $error("force bit not set by a write of one");

  a_force_no_zero: assert property (
    awrHit(busWrite, OFF_OVERRIDE) && !busWrite.data[FORCE_BIT]
      && !stepClear && !mainPorReset |=> $stable(forceChange)
  ) else $error("write of zero changed the force bit");

  a_force_step_clr: assert property (
    stepClear && !forceSet && !mainPorReset |=> !forceChange
  ) else $error("step with drive 0 did not clear force bit");

  a_override_reset: assert property (
    mainPorReset |=> overrideRead == 8'h03
  ) else $error("override register not 0x03 after main reset");

  a_disk_change_or: assert property (
    diskChangedFlag == $past(diskInSync | (drive0Sync & forceChange))
  ) else $error("disk-change flag is not the documented OR");

  a_rate_shadow_cp: assert property (
    rateWrite.strobe |=> rateShadow == ($past(rateWrite.data) & 8'hDF)
  ) else $error("rate shadow does not hold the last write");

  a_fifo_shadow_cp: assert property (
    regRd && regAddr == OFF_SERIAL2_SHADOW |=>
      regRdData == $past(serial2Shadow)
  ) else $error("serial 2 shadow read returned wrong data");

  a_fifo1_shadow: assert property (
    serial1Write.strobe |=>
      serial1Shadow == ($past(serial1Write.data) & 8'hCF)
  ) else $error("serial 1 shadow does not hold the last write");

  a_fifo2_shadow: assert property (
    serial2Write.strobe |=>
      serial2Shadow == ($past(serial2Write.data) & 8'hCF)
  ) else $error("serial 2 shadow does not hold the last write");

  a_rate_readback: assert property (
    regRd && regAddr == OFF_RATE_SHADOW |=> regRdData == $past(rateShadow)
  ) else $error("rate shadow read returned wrong data");

  a_wake_gated: assert property (
    !$past(wakeControl[WAKE_EN_BIT]) |-> wakeLineOeN
  ) else $error("wake line driven while line enable is zero");

  a_wake_keep_main: assert property (
    mainPorReset && !regWr && !(|wakeEvents) |=>
      $stable(wakeStatus) && $stable(wakeFlag)
      && $stable(wakeControl) && $stable(wakeEnable)
  ) else $error("main reset disturbed the wake registers");

  a_flag_on_fire: assert property (
    wakeFire |=> wakeFlag[WAKE_FLAG_BIT]
  ) else $error("wake flag not set by an enabled source");

  a_flag_w1c: assert property (
    awrHit(busWrite, OFF_WAKE_FLAG) && busWrite.data[WAKE_FLAG_BIT]
      && !wakeFire |=> !wakeFlag[WAKE_FLAG_BIT] ##1 wakeLineOeN
  ) else $error("wake flag clear did not release the line");

  a_status_latch: assert property (
    |wakeEvents |=>
      (wakeStatus & $past(wakeEvents)) == $past(wakeEvents)
  ) else $error("wake source event was not latched");

  a_status_w1c: assert property (
    awrHit(busWrite, OFF_WAKE_STATUS) |=>
      (wakeStatus & $past(busWrite.data & ~wakeEvents)) == 8'h00
      && (wakeStatus & $past(~busWrite.data & wakeStatus))
        == $past(~busWrite.data & wakeStatus)
  ) else $error("status write-one-clear misbehaved");

  a_wake_asserts: assert property (
    wakeFire && wakeControl[WAKE_EN_BIT] ##1 wakeControl[WAKE_EN_BIT]
      |=> !wakeLineOeN && !wakeLineOut
  ) else $error("enabled wake event did not drive the line");

  a_src_disabled: assert property (
    !(|(wakeEvents & wakeEnable)) && !wakeFlag[WAKE_FLAG_BIT]
      |=> !wakeFlag[WAKE_FLAG_BIT]
  ) else $error("disabled source set the wake flag");

  a_pin_mux_reset: assert property (
    mainPorReset |=> pinMux == 8'h02 && dma3Select && !kbcPinSelect
  ) else $error("pin multiplex not 0x02 after main reset");

  c_force_cleared: cover property (
    forceChange ##1 stepClear ##1 !forceChange
  );

  c_wake_driven: cover property (
    wakeFire ##2 !wakeLineOeN
  );

  c_wake_released: cover property (
    !wakeLineOeN ##1 awrHit(busWrite, OFF_WAKE_FLAG) ##2 wakeLineOeN
  );

  c_status_cleared: cover property (
    wakeStatus != 8'h00 ##1 awrHit(busWrite, OFF_WAKE_STATUS)
      ##1 wakeStatus == 8'h00
  );
endmodule

// ===== testbench/awr_wake_line_model.sv
// Pulled-up wake bus seen by the host side of the wake line.
`timescale 1ns/1ns
module awr_wake_line_model (
  input logic wakeLineOut,
  input logic wakeLineOeN,
  output logic wakeWire
);
  // A released open-drain line floats up to the pull-up level.
  assign wakeWire = wakeLineOeN ? 1'b1 : wakeLineOut;
endmodule

// ===== testbench/awr_regs_tb_top.sv
// Self-checking bench of the auxiliary wake and shadow register bank.
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module awr_regs_tb_top;
  import awr_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic mainPorReset = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  awr_shadow_t rateWrite = '0;
  awr_shadow_t serial1Write = '0;
  awr_shadow_t serial2Write = '0;
  logic stepPulseN = 1'b1;
  logic drive0SelectN = 1'b1;
  logic diskChangeInN = 1'b1;
  // Index 0 ring 2, 1 ring 1, 2 keyboard, 3 mouse: status bit is index+1.
  logic [3:0] wakePins = 4'h0;
  logic diskChangedFlag;
  logic dma3Select;
  logic kbcPinSelect;
  logic wakeLineOut;
  logic wakeLineOeN;
  logic wakeWire;
  int errors = 0;
  int checked = 0;

  always #50 clock = ~clock;

  awr_regs i_awr_regs (
    .clock(clock),
    .nrst(nrst),
    .mainPorReset(mainPorReset),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .rateWrite(rateWrite),
    .serial1Write(serial1Write),
    .serial2Write(serial2Write),
    .stepPulseN(stepPulseN),
    .drive0SelectN(drive0SelectN),
    .diskChangeInN(diskChangeInN),
    .ringPort1Wake(wakePins[1]),
    .ringPort2Wake(wakePins[0]),
    .keyboardWake(wakePins[2]),
    .mouseWake(wakePins[3]),
    .diskChangedFlag(diskChangedFlag),
    .dma3Select(dma3Select),
    .kbcPinSelect(kbcPinSelect),
    .wakeLineOut(wakeLineOut),
    .wakeLineOeN(wakeLineOeN)
  );

  awr_wake_line_model i_awr_wake_line_model (
    .wakeLineOut(wakeLineOut),
    .wakeLineOeN(wakeLineOeN),
    .wakeWire(wakeWire)
  );

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    `CHECK(regRdData, exp)
  endtask

  // Pins are asynchronous; six cycles cover the sync and the update.
  task automatic pins(input logic s, input logic d, input logic k);
    @(posedge clock);
    stepPulseN <= s;
    drive0SelectN <= d;
    diskChangeInN <= k;
    idle(6);
  endtask

  task automatic pulseSrc(input int i);
    @(posedge clock);
    wakePins[i] <= 1'b1;
    idle(6);
    @(posedge clock);
    wakePins[i] <= 1'b0;
    idle(4);
  endtask

  task automatic waitWire(input logic exp);
    int n;
    n = 0;
    while (wakeWire !== exp && n < 12) begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHECK(wakeWire, exp)
    if (wakeWire !== exp) begin
      report_and_stop();
    end
  endtask

  task automatic testResets();
    rd(OFF_PIN_MUX, 8'h02);
    rd(OFF_OVERRIDE, 8'h03);
    for (int a = 8'hC2; a <= 8'hC8; a++) begin
      rd(a[7:0], 8'h00);
    end
    rd(8'hC9, 8'h00);
    rd(8'hBF, 8'h00);
    idle(1);
    `CHECK(regRdData, 8'h00)
    `CHECK(dma3Select, 1'b1)
    `CHECK(kbcPinSelect, 1'b0)
    `CHECK(wakeWire, 1'b1)
    $display("test resets done");
  endtask

  task automatic testForce();
    pins(1'b1, 1'b1, 1'b0);
    `CHECK(diskChangedFlag, 1'b1)
    pins(1'b1, 1'b0, 1'b0);
    `CHECK(diskChangedFlag, 1'b0)
    pins(1'b0, 1'b0, 1'b0);
    pins(1'b1, 1'b0, 1'b0);
    rd(OFF_OVERRIDE, 8'h02);
    pins(1'b1, 1'b1, 1'b0);
    `CHECK(diskChangedFlag, 1'b0)
    wr(OFF_OVERRIDE, 8'h00);
    rd(OFF_OVERRIDE, 8'h02);
    pins(1'b1, 1'b1, 1'b1);
    `CHECK(diskChangedFlag, 1'b1)
    pins(1'b1, 1'b1, 1'b0);
    wr(OFF_OVERRIDE, 8'h01);
    rd(OFF_OVERRIDE, 8'h03);
    idle(2);
    `CHECK(diskChangedFlag, 1'b1)
    // Stepping another drive must leave the forced change in place.
    pins(1'b0, 1'b1, 1'b0);
    pins(1'b1, 1'b1, 1'b0);
    rd(OFF_OVERRIDE, 8'h03);
    pins(1'b0, 1'b0, 1'b0);
    pins(1'b1, 1'b1, 1'b1);
    $display("test force done");
  endtask

  task automatic testShadows();
    @(posedge clock);
    rateWrite <= '{1'b1, 8'h25};
    serial1Write <= '{1'b1, 8'hFF};
    serial2Write <= '{1'b1, 8'h41};
    @(posedge clock);
    rateWrite <= '{1'b1, 8'hFF};
    serial1Write.strobe <= 1'b0;
    serial2Write.strobe <= 1'b0;
    @(posedge clock);
    rateWrite.strobe <= 1'b0;
    rd(OFF_RATE_SHADOW, 8'hDF);
    rd(OFF_SERIAL1_SHADOW, 8'hCF);
    rd(OFF_SERIAL2_SHADOW, 8'h41);
    wr(OFF_RATE_SHADOW, 8'h00);
    wr(OFF_SERIAL2_SHADOW, 8'h00);
    rd(OFF_RATE_SHADOW, 8'hDF);
    rd(OFF_SERIAL2_SHADOW, 8'h41);
    $display("test shadows done");
  endtask

  task automatic testSources();
    logic [7:0] b;
    wr(OFF_WAKE_CTRL, 8'h01);
    for (int i = 0; i < 4; i++) begin
      b = 8'h02 << i;
      wr(OFF_WAKE_ENABLE, b);
      pulseSrc(i);
      waitWire(1'b0);
      rd(OFF_WAKE_STATUS, b);
      rd(OFF_WAKE_FLAG, 8'h01);
      wr(OFF_WAKE_FLAG, 8'h00);
      rd(OFF_WAKE_FLAG, 8'h01);
      `CHECK(wakeWire, 1'b0)
      wr(OFF_WAKE_FLAG, 8'h01);
      waitWire(1'b1);
      rd(OFF_WAKE_FLAG, 8'h00);
      wr(OFF_WAKE_STATUS, 8'h00);
      rd(OFF_WAKE_STATUS, b);
      wr(OFF_WAKE_STATUS, b);
      rd(OFF_WAKE_STATUS, 8'h00);
    end
    $display("test sources done");
  endtask

  task automatic testGated();
    wr(OFF_WAKE_CTRL, 8'h01);
    wr(OFF_WAKE_ENABLE, 8'h00);
    pulseSrc(3);
    `CHECK(wakeWire, 1'b1)
    rd(OFF_WAKE_STATUS, 8'h10);
    rd(OFF_WAKE_FLAG, 8'h00);
    wr(OFF_WAKE_CTRL, 8'h00);
    wr(OFF_WAKE_ENABLE, 8'h08);
    pulseSrc(2);
    `CHECK(wakeWire, 1'b1)
    rd(OFF_WAKE_FLAG, 8'h01);
    rd(OFF_WAKE_STATUS, 8'h18);
    wr(OFF_WAKE_CTRL, 8'h01);
    waitWire(1'b0);
    wr(OFF_WAKE_FLAG, 8'h01);
    wr(OFF_WAKE_STATUS, 8'h1E);
    waitWire(1'b1);
    rd(OFF_WAKE_STATUS, 8'h00);
    $display("test gated done");
  endtask

  task automatic testMainReset();
    wr(OFF_PIN_MUX, 8'hFF);
    rd(OFF_PIN_MUX, 8'h0A);
    `CHECK(kbcPinSelect, 1'b1)
    wr(OFF_PIN_MUX, 8'h00);
    rd(OFF_PIN_MUX, 8'h00);
    `CHECK(dma3Select, 1'b0)
    wr(OFF_WAKE_ENABLE, 8'h1E);
    // Leave a latched event and a driven line across the main reset.
    pulseSrc(0);
    @(posedge clock);
    mainPorReset <= 1'b1;
    @(posedge clock);
    mainPorReset <= 1'b0;
    rd(OFF_PIN_MUX, 8'h02);
    rd(OFF_OVERRIDE, 8'h03);
    rd(OFF_WAKE_CTRL, 8'h01);
    rd(OFF_WAKE_ENABLE, 8'h1E);
    rd(OFF_WAKE_FLAG, 8'h01);
    rd(OFF_WAKE_STATUS, 8'h02);
    `CHECK(wakeWire, 1'b0)
    // Only the standby reset may clear the wake registers.
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    idle(3);
    rd(OFF_WAKE_CTRL, 8'h00);
    rd(OFF_WAKE_ENABLE, 8'h00);
    rd(OFF_WAKE_FLAG, 8'h00);
    rd(OFF_WAKE_STATUS, 8'h00);
    `CHECK(wakeWire, 1'b1)
    $display("test main reset done");
  endtask

  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    idle(3);
    testResets();
    testForce();
    testShadows();
    testSources();
    testGated();
    testMainReset();
    report_and_stop();
  end
endmodule
